// ===== core/cipc_device.sv
/*
 * Two cascaded priority request controllers with masks, in-service state,
 * vector delivery and service done command over the processor link.
 * Assumes request inputs are synchronous to pclk and that the processor
 * holds a link request until it sees io_ack.
 */
// Our own choice: register access over APB.
`timescale 1ns/1ps
`include "cipc_consts.svh"

// Notes on behaviour
// - Bus lines request on rising edge only
// - PCI lines request by level while held
// - Line 0 highest, line 7 lowest
// - Only higher priority preempts; others stay pending
// - Interrupt only when unmasked and winning arbitration
// - Mask bit n governs line n
// - Mask one blocks, mask zero allows
// - Primary mask read and written at 21h
// - Processor reads 8-bit vector of winner
// - Processor sends service done command; releases service
// - Agent clears source flag before service done
// - Requests spaced 125 ns apart are accepted
// - Two cascaded controllers, 13 usable lines
// - Eight lines each, own mask, own priority
// - Shared level line held until all withdraw
module cipc_device
    import cipc_pkg::*;
(
    input wire logic pclk, // System clock.
    input wire logic presetn, // Asynchronous reset, active low.
    cipc_if.dev link, // Processor link.
    input wire logic [15:0] bus_req, // Expansion bus request lines.
    input wire logic [3:0] pci_src // PCI request sources, high requests.
);

    // ------------------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------------------
    // Returns {found, index} of the best unmasked request not blocked by an
    // equal or higher in-service line; a line set in nest passes its own.
    function automatic logic [3:0] arbitrate(
        input logic [7:0] req,
        input logic [7:0] mask,
        input logic [7:0] svc,
        input logic [7:0] nest
    );
        logic [7:0] cand;
        logic done;
        logic [3:0] res;
        cand = req & ~mask;
        done = 1'b0;
        res = 4'h0;
        for (int i = 0; i < 8; i++) begin
            if (!done) begin
                if (cand[i] && (nest[i] || !svc[i])) begin
                    res = {1'b1, 3'(i)};
                    done = 1'b1;
                end else if (svc[i]) begin
                    done = 1'b1;
                end
            end
        end
        return res;
    endfunction

    // One-hot of the lowest set bit, that is the highest priority in service.
    function automatic logic [7:0] top_bit(input logic [7:0] v);
        return v & (~v + 8'h01);
    endfunction

    // Index of a secondary line among all sixteen lines.
    function automatic logic [3:0] sec_line(input logic [2:0] idx);
        return {1'b1, idx};
    endfunction

    // Vector number of line idx of a controller whose first vector is base.
    function automatic logic [7:0] vector_of(input logic [7:0] base, input logic [2:0] idx);
        return base + {5'h00, idx};
    endfunction

    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    cipc_dev_s s_reg;
    cipc_dev_s s_next;

    logic [15:0] rise;
    logic [15:0] level;
    logic [15:0] irr;
    logic [7:0] pri_irr;
    logic [7:0] pri_nest;
    logic [3:0] sec_win;
    logic [3:0] pri_win;
    logic take;
    logic [15:0] irr_clr;
    logic [15:0] isr_set;
    logic [15:0] isr_clr;

    // ------------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------------
    always_comb begin
        s_next = s_reg;
        irr_clr = 16'h0000;
        isr_set = 16'h0000;
        isr_clr = 16'h0000;

        // --------------------------------------------------------------------
        // Request sensing
        // --------------------------------------------------------------------
        // Edge lines latch a request on each low to high step; a step every
        // second cycle is caught, so the 125 ns spacing is met with margin.
        rise = bus_req & ~s_reg.prev & ~`CIPC_LEVEL_LINES;
        s_next.prev = bus_req;

        // Shared PCI lines are the OR of their sources, live each cycle.
        level = ({16{pci_src[0] | pci_src[2]}} & `CIPC_PCI_ROUTE_A)
              | ({16{pci_src[1] | pci_src[3]}} & `CIPC_PCI_ROUTE_B);

        irr = (s_reg.irr_edge | level) & `CIPC_USABLE_LINES;

        // --------------------------------------------------------------------
        // Arbitration
        // --------------------------------------------------------------------
        // A secondary winner may preempt the secondary line in service.
        pri_nest = 8'h00;
        pri_nest[`CIPC_CASCADE_IDX] = 1'b1;
        sec_win = arbitrate(irr[15:8], s_reg.irq_mask_primary[15:8], s_reg.service_routine[15:8], 8'h00);
        pri_irr = irr[7:0];
        pri_irr[`CIPC_CASCADE_IDX] = sec_win[3];
        pri_win = arbitrate(pri_irr, s_reg.irq_mask_primary[7:0], s_reg.service_routine[7:0], pri_nest);
        s_next.intr = pri_win[3];

        // --------------------------------------------------------------------
        // Link transfers
        // --------------------------------------------------------------------
        take = link.io_req && !s_reg.io_ack;
        s_next.io_ack = take;

        if (take && link.io_inta) begin
            if (!pri_win[3]) begin
                s_next.io_rdata = vector_of(`CIPC_PRI_VEC_BASE, `CIPC_SPURIOUS_IDX);
            end else if (pri_win[2:0] == `CIPC_CASCADE_IDX) begin
                s_next.io_rdata = vector_of(`CIPC_SEC_VEC_BASE, sec_win[2:0]);
                isr_set[`CIPC_CASCADE_IDX] = 1'b1;
                isr_set[sec_line(sec_win[2:0])] = 1'b1;
                irr_clr[sec_line(sec_win[2:0])] = 1'b1;
            end else begin
                s_next.io_rdata = vector_of(`CIPC_PRI_VEC_BASE, pri_win[2:0]);
                isr_set[pri_win[2:0]] = 1'b1;
                irr_clr[pri_win[2:0]] = 1'b1;
            end
        end else if (take && link.io_wr) begin
            unique case (link.io_addr)
                `CIPC_PORT_PRI_MASK: begin
                    s_next.irq_mask_primary[7:0] = link.io_wdata;
                end
                `CIPC_PORT_SEC_MASK: begin
                    s_next.irq_mask_primary[15:8] = link.io_wdata;
                end
                `CIPC_PORT_PRI_CMD: begin
                    if (link.io_wdata == `CIPC_SERVICE_DONE_CMD) begin
                        isr_clr[7:0] = top_bit(s_reg.service_routine[7:0]);
                    end
                end
                `CIPC_PORT_SEC_CMD: begin
                    if (link.io_wdata == `CIPC_SERVICE_DONE_CMD) begin
                        isr_clr[15:8] = top_bit(s_reg.service_routine[15:8]);
                    end
                end
                default: begin
                end
            endcase
        end else if (take) begin
            unique case (link.io_addr)
                `CIPC_PORT_PRI_MASK: s_next.io_rdata = s_reg.irq_mask_primary[7:0];
                `CIPC_PORT_SEC_MASK: s_next.io_rdata = s_reg.irq_mask_primary[15:8];
                `CIPC_PORT_PRI_CMD: s_next.io_rdata = s_reg.service_routine[7:0];
                `CIPC_PORT_SEC_CMD: s_next.io_rdata = s_reg.service_routine[15:8];
                default: s_next.io_rdata = 8'h00;
            endcase
        end

        // --------------------------------------------------------------------
        // Pending and in-service update
        // --------------------------------------------------------------------
        // A new edge in the cycle of acknowledge is kept as a fresh request.
        s_next.irr_edge = ((s_reg.irr_edge & ~irr_clr) | rise) & `CIPC_USABLE_LINES;
        s_next.service_routine = (s_reg.service_routine & ~isr_clr) | isr_set;
    end

    // ------------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_reg <= '{prev: 16'h0000, irr_edge: 16'h0000, service_routine: 16'h0000,
                       irq_mask_primary: `CIPC_MASK_RESET, intr: 1'b0, io_ack: 1'b0,
                       io_rdata: 8'h00};
        end else begin
            s_reg <= s_next;
        end
    end

    assign link.intr = s_reg.intr;
    assign link.io_ack = s_reg.io_ack;
    assign link.io_rdata = s_reg.io_rdata;

endmodule

// ===== shared/cipc_consts.svh
/*
 * Named constants of the cascaded interrupt controller pair and its host end.
 * Assumes inclusion by the package and the design modules.
 */
`ifndef CIPC_CONSTS_SVH
`define CIPC_CONSTS_SVH

// ----------------------------------------------------------------------------
// Controller ports and commands
// ----------------------------------------------------------------------------
`define CIPC_PORT_PRI_CMD 8'h20
`define CIPC_PORT_PRI_MASK 8'h21
`define CIPC_PORT_SEC_CMD 8'hA0
`define CIPC_PORT_SEC_MASK 8'hA1
`define CIPC_SERVICE_DONE_CMD 8'h20
`define CIPC_MASK_RESET 16'hFFFF
`define CIPC_PRI_VEC_BASE 8'h08
`define CIPC_SEC_VEC_BASE 8'h70
`define CIPC_SPURIOUS_IDX 3'h7
`define CIPC_CASCADE_IDX 3'h2
`define CIPC_USABLE_LINES 16'hDEFB
`define CIPC_LEVEL_LINES 16'h0C00
`define CIPC_PCI_ROUTE_A 16'h0400
`define CIPC_PCI_ROUTE_B 16'h0800
`define CIPC_REQ_GAP_NS 125
`define CIPC_CLK_NS 4
`define CIPC_REQ_GAP_CYC ((`CIPC_REQ_GAP_NS) / (`CIPC_CLK_NS))

// ----------------------------------------------------------------------------
// Host register map and fields
// ----------------------------------------------------------------------------
`define CIPC_REG_CMD 8'h00
`define CIPC_REG_STATUS 8'h04
`define CIPC_REG_IRQ_STAT 8'h08
`define CIPC_REG_IRQ_CLR 8'h0C
`define CIPC_REG_IRQ_EN 8'h10
`define CIPC_CMD_WR_BIT 16
`define CIPC_CMD_INTA_BIT 17
`define CIPC_EV_INTR 0
`define CIPC_EV_DONE 1
`define CIPC_IRQ_EN_RESET 2'h0

`endif

// ===== shared/cipc_pkg.sv
/*
 * Types shared by both ends: the state records of each end.
 * Assumes the constants header is on the include path.
 */
package cipc_pkg;

    // ------------------------------------------------------------------------
    // Device state
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic [15:0] prev;
        logic [15:0] irr_edge;
        logic [15:0] service_routine;
        logic [15:0] irq_mask_primary;
        logic intr;
        logic io_ack;
        logic [7:0] io_rdata;
    } cipc_dev_s;

    // ------------------------------------------------------------------------
    // Host state
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic io_req;
        logic io_wr;
        logic io_inta;
        logic [7:0] io_addr;
        logic [7:0] io_wdata;
        logic [7:0] rdata;
        logic intr_prev;
        logic [1:0] stat;
        logic [1:0] en;
        logic irq;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } cipc_host_s;

endpackage

// ===== shared/cipc_if.sv
/*
 * Link between the controller pair and the processor end.
 * Assumes both ends run on the same clock and reset.
 */
`timescale 1ns/1ps
interface cipc_if;
    logic io_req;
    logic io_wr;
    logic io_inta;
    logic [7:0] io_addr;
    logic [7:0] io_wdata;
    logic [7:0] io_rdata;
    logic io_ack;
    logic intr;

    modport dev (
        input io_req, io_wr, io_inta, io_addr, io_wdata,
        output io_rdata, io_ack, intr
    );
    modport cpu (
        output io_req, io_wr, io_inta, io_addr, io_wdata,
        input io_rdata, io_ack, intr
    );
endinterface

// ===== core/cipc_cpu.sv
/*
 * Processor end: an APB slave whose command register launches link cycles
 * (port read, port write, vector read), with status and an interrupt block.
 * Assumes an APB master on pclk and the controller pair on the link.
 */
`timescale 1ns/1ps
`include "cipc_consts.svh"

module cipc_cpu
    import cipc_pkg::*;
(
    input wire logic pclk, // System clock.
    input wire logic presetn, // Asynchronous reset, active low.
    input wire logic psel, // APB select.
    input wire logic penable, // APB enable.
    input wire logic pwrite, // APB write.
    input wire logic [7:0] paddr, // APB byte address.
    input wire logic [31:0] pwdata, // APB write data.
    output logic [31:0] prdata, // APB read data.
    output logic pready, // APB ready.
    output logic pslverr, // APB error on unmapped address.
    output logic irq, // Level interrupt to software.
    cipc_if.cpu link // Link to the controller pair.
);

    cipc_host_s s_reg;
    cipc_host_s s_next;
    logic acc;
    logic fin;
    logic [1:0] ev;
    logic [1:0] clr;

    // ------------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------------
    always_comb begin
        s_next = s_reg;
        s_next.pready = 1'b0;
        s_next.pslverr = 1'b0;
        ev = 2'b00;
        clr = 2'b00;

        // The link request is dropped on the edge that sees the answer.
        if (s_reg.io_req && link.io_ack) begin
            s_next.io_req = 1'b0;
            s_next.rdata = link.io_rdata;
            ev[`CIPC_EV_DONE] = 1'b1;
        end
        ev[`CIPC_EV_INTR] = link.intr && !s_reg.intr_prev;
        s_next.intr_prev = link.intr;

        acc = psel && penable && !s_reg.pready;
        fin = psel && penable && s_reg.pready && pwrite;
        s_next.pready = acc;
        if (acc) begin
            s_next.prdata = 32'h0000_0000;
            unique case (paddr)
                `CIPC_REG_CMD: begin
                    if (!pwrite) begin
                        s_next.prdata = {14'h0000, s_reg.io_inta, s_reg.io_wr,
                                         s_reg.io_wdata, s_reg.io_addr};
                    end
                end
                `CIPC_REG_STATUS: begin
                    if (!pwrite) begin
                        s_next.prdata = {22'h000000, link.intr, s_reg.io_req,
                                         s_reg.rdata};
                    end
                end
                `CIPC_REG_IRQ_STAT: begin
                    if (!pwrite) begin
                        s_next.prdata = {30'h00000000, s_reg.stat};
                    end
                end
                `CIPC_REG_IRQ_CLR: begin
                end
                `CIPC_REG_IRQ_EN: begin
                    if (!pwrite) begin
                        s_next.prdata = {30'h00000000, s_reg.en};
                    end
                end
                default: begin
                    s_next.pslverr = 1'b1;
                end
            endcase
        end

        // Writes take effect at the edge that sees pready high.
        if (fin) begin
            unique case (paddr)
                `CIPC_REG_CMD: begin
                    if (!s_reg.io_req) begin
                        s_next.io_req = 1'b1;
                        s_next.io_addr = pwdata[7:0];
                        s_next.io_wdata = pwdata[15:8];
                        s_next.io_wr = pwdata[`CIPC_CMD_WR_BIT];
                        s_next.io_inta = pwdata[`CIPC_CMD_INTA_BIT];
                    end
                end
                `CIPC_REG_IRQ_CLR: begin
                    clr = pwdata[1:0];
                end
                `CIPC_REG_IRQ_EN: begin
                    s_next.en = pwdata[1:0];
                end
                default: begin
                end
            endcase
        end

        // An event in the cycle of its clear keeps its status bit set.
        s_next.stat = (s_reg.stat & ~clr) | ev;
        s_next.irq = |(s_next.stat & s_next.en);
    end

    // ------------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_reg <= '{io_req: 1'b0, io_wr: 1'b0, io_inta: 1'b0, io_addr: 8'h00,
                       io_wdata: 8'h00, rdata: 8'h00, intr_prev: 1'b0,
                       stat: 2'h0, en: `CIPC_IRQ_EN_RESET, irq: 1'b0,
                       pready: 1'b0, pslverr: 1'b0, prdata: 32'h0000_0000};
        end else begin
            s_reg <= s_next;
        end
    end

    assign prdata = s_reg.prdata;
    assign pready = s_reg.pready;
    assign pslverr = s_reg.pslverr;
    assign irq = s_reg.irq;
    assign link.io_req = s_reg.io_req;
    assign link.io_wr = s_reg.io_wr;
    assign link.io_inta = s_reg.io_inta;
    assign link.io_addr = s_reg.io_addr;
    assign link.io_wdata = s_reg.io_wdata;

endmodule

// ===== verif/cipc_monitor.sv
/* Checker of the link between the controller pair and the processor end.
   Assumes the link signals of one interface, one clock and one reset. */
`timescale 1ns/1ps
module cipc_monitor (
    input wire logic pclk, // Clock.
    input wire logic presetn, // Reset, active low.
    input wire logic io_req, // Request.
    input wire logic io_wr, // Write.
    input wire logic io_inta, // Vector read.
    input wire logic [7:0] io_addr, // Port.
    input wire logic [7:0] io_wdata, // Write data.
    input wire logic [7:0] io_rdata, // Read data.
    input wire logic io_ack, // Answer.
    input wire logic intr // Interrupt line.
);
    // ------------------------------------------------------------------
    // Shadow of the primary mask
    // ------------------------------------------------------------------
    logic [7:0] pmask_reg;
    logic rd21;
    assign rd21 = io_ack && !io_wr && !io_inta && io_addr == 8'h21;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pmask_reg <= 8'hFF;
        end else if (io_ack && io_wr && !io_inta && io_addr == 8'h21) begin
            pmask_reg <= io_wdata;
        end
    end
    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_taken;
        io_req && !io_ack;
    endsequence
    sequence s_answer;
        io_ack ##1 !io_ack;
    endsequence
    property p_handshake;
        s_taken |=> s_answer;
    endproperty
    property p_ack_cause;
        io_ack |-> $past(io_req) && !$past(io_ack);
    endproperty
    property p_vec_range;
        io_ack && io_inta |-> io_rdata inside {[8'h08:8'h0F], [8'h70:8'h77]};
    endproperty
    property p_reserved_vec;
        io_ack && io_inta |-> !(io_rdata inside {8'h0A, 8'h70, 8'h75});
    endproperty
    property p_mask_readback;
        rd21 |-> io_rdata == pmask_reg;
    endproperty
    property p_masked_quiet;
        pmask_reg == 8'hFF && $past(pmask_reg) == 8'hFF |-> !intr;
    endproperty
    property p_spurious;
        io_ack && io_inta && pmask_reg == 8'hFF |-> io_rdata == 8'h0F;
    endproperty
    property p_rdata_hold;
        !io_ack |-> $stable(io_rdata);
    endproperty
    a_handshake: assert property (p_handshake) else $error("link answer late");
    a_ack_cause: assert property (p_ack_cause) else $error("answer without request");
    a_vec_range: assert property (p_vec_range) else $error("vector out of range");
    a_reserved_vec: assert property (p_reserved_vec) else $error("reserved vector");
    a_mask_readback: assert property (p_mask_readback) else $error("mask readback");
    a_masked_quiet: assert property (p_masked_quiet) else $error("masked intr");
    a_spurious: assert property (p_spurious) else $error("vector while masked");
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
    c_vector: cover property (io_ack && io_inta && io_rdata == 8'h71);
endmodule

// ===== verif/test_cascaded_irq_priority_controller.sv
/* Bench for the controller pair: APB master on the processor end, request lines
   and PCI sources driven directly. Assumes the design, interface and checker. */
`timescale 1ns/1ps
module test_cascaded_irq_priority_controller;
    // ------------------------------------------------------------------
    // Signals and instances
    // ------------------------------------------------------------------
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic perr;
    logic [31:0] r;
    logic [15:0] bus_req = 16'h0000;
    logic [3:0] pci_src = 4'h0;
    int num_errors = 0;
    int tests_run = 0;
    cipc_if lk ();
    cipc_device cipc_device_i (.pclk, .presetn, .link(lk.dev), .bus_req, .pci_src);
    cipc_cpu cipc_cpu_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .irq, .link(lk.cpu));
    cipc_monitor cipc_monitor_i (.pclk, .presetn, .io_req(lk.io_req), .io_wr(lk.io_wr),
        .io_inta(lk.io_inta), .io_addr(lk.io_addr), .io_wdata(lk.io_wdata),
        .io_rdata(lk.io_rdata), .io_ack(lk.io_ack), .intr(lk.intr));
    initial begin
        forever #2 pclk = ~pclk;
    end
    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        q = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task lnk(input logic [7:0] port, input logic [7:0] wd, input logic [1:0] k,
        output logic [7:0] rd);
        logic [31:0] s;
        int n;
        apb(1'b1, 8'h00, {14'h0, k, wd, port}, s);
        s = 32'h100;
        n = 0;
        while (s[8] !== 1'b0 && n < 20) begin
            apb(1'b0, 8'h04, 32'h0, s);
            n++;
        end
        chk(s[8], 1'b0);
        rd = s[7:0];
    endtask
    task vec(input logic [7:0] exp);
        logic [7:0] v;
        lnk(8'h00, 8'h00, 2'b10, v);
        chk(v, exp);
    endtask
    task wr(input logic [7:0] port, input logic [7:0] d);
        logic [7:0] v;
        lnk(port, d, 2'b01, v);
    endtask
    task eoi2;
        wr(8'hA0, 8'h20);
        wr(8'h20, 8'h20);
    endtask
    task rq(input logic [15:0] b, input logic [3:0] p);
        @(posedge pclk);
        bus_req <= b;
        pci_src <= p;
        repeat (32) @(posedge pclk);
    endtask
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task t_reset;
        logic [7:0] v;
        apb(1'b0, 8'h14, 32'h0, r);
        chk(perr, 1'b1);
        lnk(8'h21, 8'h00, 2'b00, v);
        chk(v, 8'hFF);
        lnk(8'hA1, 8'h00, 2'b00, v);
        chk(v, 8'hFF);
        rq(16'h0008, 4'h0);
        vec(8'h0F);
        wr(8'h21, 8'h00);
        wr(8'hA1, 8'h00);
        lnk(8'h21, 8'h00, 2'b00, v);
        chk(v, 8'h00);
        vec(8'h0B);
        wr(8'h20, 8'h20);
        rq(16'h0000, 4'h0);
        $display("t_reset done");
    endtask
    task t_prio;
        rq(16'h0028, 4'h0);
        apb(1'b0, 8'h04, 32'h0, r);
        chk(r[9], 1'b1);
        vec(8'h0B);
        vec(8'h0F);
        wr(8'h20, 8'h20);
        vec(8'h0D);
        wr(8'h20, 8'h20);
        vec(8'h0F);
        rq(16'h0000, 4'h0);
        $display("t_prio done");
    endtask
    task t_preempt;
        logic [7:0] v;
        rq(16'h0040, 4'h0);
        vec(8'h0E);
        rq(16'h0042, 4'h0);
        vec(8'h09);
        lnk(8'h20, 8'h00, 2'b00, v);
        chk(v, 8'h42);
        rq(16'h0062, 4'h0);
        vec(8'h0F);
        wr(8'h20, 8'h20);
        vec(8'h0D);
        wr(8'h20, 8'h20);
        wr(8'h20, 8'h20);
        rq(16'h0000, 4'h0);
        $display("t_preempt done");
    endtask
    task t_mask;
        wr(8'h21, 8'h10);
        rq(16'h0010, 4'h0);
        apb(1'b0, 8'h04, 32'h0, r);
        chk(r[9], 1'b0);
        vec(8'h0F);
        wr(8'h21, 8'h00);
        vec(8'h0C);
        wr(8'h20, 8'h20);
        wr(8'hA1, 8'h02);
        rq(16'h0200, 4'h0);
        vec(8'h0F);
        wr(8'hA1, 8'h00);
        vec(8'h71);
        eoi2();
        rq(16'h0000, 4'h0);
        $display("t_mask done");
    endtask
    task t_irq;
        apb(1'b1, 8'h0C, 32'h3, r);
        apb(1'b1, 8'h10, 32'h1, r);
        rq(16'h0002, 4'h0);
        chk(irq, 1'b1);
        apb(1'b1, 8'h10, 32'h0, r);
        @(posedge pclk);
        chk(irq, 1'b0);
        vec(8'h09);
        apb(1'b1, 8'h0C, 32'h1, r);
        apb(1'b0, 8'h08, 32'h0, r);
        chk(r[0], 1'b0);
        chk(r[1], 1'b1);
        rq(16'h0000, 4'h0);
        wr(8'h20, 8'h20);
        $display("t_irq done");
    endtask
    task t_cascade;
        rq(16'h0200, 4'h0);
        vec(8'h71);
        vec(8'h0F);
        eoi2();
        rq(16'h2100, 4'h0);
        vec(8'h0F);
        rq(16'h0000, 4'h1);
        vec(8'h72);
        eoi2();
        vec(8'h72);
        vec(8'h0F);
        eoi2();
        rq(16'h0000, 4'h5);
        rq(16'h0000, 4'h4);
        vec(8'h72);
        eoi2();
        rq(16'h0000, 4'h8);
        vec(8'h73);
        eoi2();
        rq(16'h0000, 4'h0);
        vec(8'h0F);
        $display("t_cascade done");
    endtask
    task conclude;
        $display("comparisons %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        #200000;
        num_errors++;
        conclude();
    end
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_prio();
        t_preempt();
        t_mask();
        t_irq();
        t_cascade();
        conclude();
    end
endmodule
